// file: core/bbsc_map.svh
// Purpose: offsets, field positions, reset values and counts of the
//          system control coprocessor register file
// Assumes: register byte address is four times the register number
// Notes:   definitions only
`ifndef BBSC_MAP_SVH
`define BBSC_MAP_SVH

// ------
// register numbers
// ------
`define BBSC_IDX_INSTR_SPACE_BASE 5'h00
`define BBSC_IDX_ILIMIT 5'h01
`define BBSC_IDX_DATA_SPACE_BASE 5'h02
`define BBSC_IDX_DLIMIT 5'h03
`define BBSC_IDX_FVADDR 5'h08
`define BBSC_IDX_COUNT 5'h09
`define BBSC_IDX_MATCH 5'h0b
`define BBSC_IDX_STATE 5'h0c
`define BBSC_IDX_REASON 5'h0d
`define BBSC_IDX_EPC 5'h0e
`define BBSC_IDX_IDENT 5'h0f
`define BBSC_IDX_SYSATTR 5'h10
`define BBSC_IDX_CPOLICY 5'h11
`define BBSC_IDX_FWATCH 5'h12
`define BBSC_IDX_DATA_BREAKPOINT_ADDR 5'h13
`define BBSC_IDX_CCHECK 5'h1a
`define BBSC_IDX_CERR 5'h1b
`define BBSC_IDX_CTAG 5'h1c
`define BBSC_IDX_CFEPC 5'h1e

// ------
// processor_state fields
// ------
`define BBSC_ST_IE 0
`define BBSC_ST_EXL 1
`define BBSC_ST_ERL 2
`define BBSC_ST_USER 4
`define BBSC_ST_IM_TIMER 15
`define BBSC_ST_IVEC 24
`define BBSC_ST_CU0 28
`define BBSC_ST_CU1 29
`define BBSC_STATE_RST 32'h0000_0004

// ------
// exception_reason fields
// ------
`define BBSC_RS_CODE_LO 2
`define BBSC_RS_SOFT_LO 8
`define BBSC_RS_TIMER 15
`define BBSC_RS_SOFT_MASK 32'h0000_0300

// ------
// watch register fields, cache policy, vectors, counts
// ------
`define BBSC_WATCH_EN 0
`define BBSC_CPOL_UNCACHED 4'h2
`define BBSC_CPOL_RST 32'h3333_3333
`define BBSC_VEC_GENERAL 32'h8000_0180
`define BBSC_VEC_INTR 32'h8000_0200
`define BBSC_COUNT_DIV 2
`define BBSC_WORD_RST 32'h0000_0000

`endif

// file: core/bbsc_pkg.sv
// Purpose: shared types of the system control coprocessor
// Assumes: nothing
// Notes:   constants live in bbsc_map.svh
package bbsc_pkg;

  typedef logic [31:0] bbsc_word_t;

  typedef enum logic [4:0] {
    BBSC_EXC_INTR = 5'b0_0000,
    BBSC_EXC_ADDR_LOAD = 5'b0_0100,
    BBSC_EXC_ADDR_STORE = 5'b0_0101,
    BBSC_EXC_WATCH = 5'b1_0111
  } bbsc_exc_t;

  typedef enum logic [1:0] {
    BBSC_RESP_OKAY = 2'b00,
    BBSC_RESP_SLVERR = 2'b10
  } bbsc_resp_t;

endpackage : bbsc_pkg

// file: core/bbsc_addr_xlate.sv
// Purpose: one address translation port (fetch or data side)
// Assumes: request inputs come from logic on clk
// Notes:   results registered, one cycle after the request
`include "bbsc_map.svh"
module bbsc_addr_xlate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire bbsc_pkg::bbsc_word_t vaddr,
  input wire logic userMode,
  input wire bbsc_pkg::bbsc_word_t spaceBase,
  input wire bbsc_pkg::bbsc_word_t spaceLimit,
  input wire bbsc_pkg::bbsc_word_t regionPolicy,
  input wire bbsc_pkg::bbsc_word_t watchAddr,
  output logic outValid,
  output bbsc_pkg::bbsc_word_t outVaddr,
  output bbsc_pkg::bbsc_word_t outPaddr,
  output logic outCached,
  output logic [3:0] outPolicy,
  output logic outFault,
  output logic outWatchHit
);

  // ------
  // combinational translation
  // ------
  logic [2:0] region;
  logic [3:0] policy;
  logic inBounds;
  logic nxt_fault;
  logic nxt_cached;
  bbsc_pkg::bbsc_word_t nxt_paddr;

  assign region = vaddr[31:29];
  assign policy = 4'(regionPolicy >> {region, 2'b00}); // [R19]
  // bound is inclusive: limit holds the highest legal address
  assign inBounds = (vaddr <= spaceLimit); // [R7]

  always_comb begin
    nxt_fault = 1'b0;
    nxt_cached = (policy != `BBSC_CPOL_UNCACHED);
    nxt_paddr = vaddr; // [R10] [R14]
    if (userMode) begin
      // [R5] [R6] user may only touch the lower 2GB
      if (vaddr[31] || !inBounds) begin
        nxt_fault = 1'b1; // [R9]
      end else begin
        nxt_paddr = vaddr + spaceBase; // [R8] [R11]
      end
    end else begin
      case (region)
        3'b100: begin
          nxt_paddr = {3'b000, vaddr[28:0]}; // [R12] [R21]
          nxt_cached = 1'b1;
        end
        3'b101: begin
          nxt_paddr = {3'b000, vaddr[28:0]}; // [R13] [R21]
          nxt_cached = 1'b0;
        end
        default: begin
          nxt_paddr = vaddr; // [R4] [R10]
        end
      endcase
    end
  end

  // ------
  // result registers
  // ------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      outValid <= 1'b0;
      outVaddr <= `BBSC_WORD_RST;
      outPaddr <= `BBSC_WORD_RST;
      outCached <= 1'b0;
      outPolicy <= 4'h0;
      outFault <= 1'b0;
      outWatchHit <= 1'b0;
    end else begin
      outValid <= reqValid;
      outFault <= reqValid && nxt_fault;
      outWatchHit <= reqValid && watchAddr[`BBSC_WATCH_EN]
                     && (vaddr[31:2] == watchAddr[31:2]); // [R15]
      if (reqValid) begin
        outVaddr <= vaddr;
        outPaddr <= nxt_fault ? `BBSC_WORD_RST : nxt_paddr;
        outCached <= nxt_cached;
        outPolicy <= policy;
      end
    end
  end

endmodule : bbsc_addr_xlate

// file: core/bbsc_system_control.sv
// Purpose: system control coprocessor: modes, base-bounds translation,
//          cycle timer, watch points, exception state registers
// Assumes: pipeline signals are on clk; registers reached over AXI4-Lite
// Notes:   byte address of a register is four times its number
//
// What this block does
// [R1]: cycle counter advances once every two clock cycles.
// [R2]: timer interrupt raised when counter reaches the match value.
// [R3]: kernel mode entered on reset and on every exception.
// [R4]: kernel reaches all addresses and registers, chooses float access.
// [R5]: user confined to user region, may be barred from control registers.
// [R6]: 4GB split; user access to kernel-only regions refused.
// [R7]: user address compared to instruction or data limit.
// [R8]: in-limit user address gets matching base added.
// [R9]: out-of-limit user address signals an address exception.
// [R10]: kernel addresses skip base-bounds, get fixed translation.
// [R11]: lower 2GB is the mapped user region.
// [R12]: 0.5GB at 0x80000000 unmapped and cacheable.
// [R13]: 0.5GB at 0xA0000000 unmapped and uncached.
// [R14]: 1GB at 0xC0000000 kernel-only and unmapped.
// [R15]: enabled watch address hit on fetch or data raises exception.
// [R16]: kernel may enable a separate interrupt vector.
// [R17]: address exception captures offending virtual address.
// [R18]: cache-error restart address kept in its own return register.
// [R19]: cache policy register holds one attribute per 512MB region.
// [R20]: numbers 4-7, 10, 20-25, 29, 31 are unimplemented.
// [R21]: both half-gigabyte windows alias lowest 512MB physical.
// [R22]: unimplemented numbers read zero and ignore writes.
`include "bbsc_map.svh"
module bbsc_system_control #(
  parameter int ADDR_W = 8,
  parameter bbsc_pkg::bbsc_word_t IDENT_VALUE = 32'h0000_0a5a // arbitrary
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire bbsc_pkg::bbsc_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output bbsc_pkg::bbsc_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetchValid,
  input wire bbsc_pkg::bbsc_word_t fetchVaddr,
  output logic fetchDone,
  output bbsc_pkg::bbsc_word_t fetchPaddr,
  output logic fetchCached,
  output logic fetchFault,
  output logic fetchWatchHit,
  input wire logic dataValid,
  input wire bbsc_pkg::bbsc_word_t dataVaddr,
  output logic dataDone,
  output bbsc_pkg::bbsc_word_t dataPaddr,
  output logic dataCached,
  output logic [3:0] dataPolicy,
  output logic dataFault,
  output logic dataWatchHit,
  input wire logic excValid,
  input wire logic [4:0] excCode,
  input wire bbsc_pkg::bbsc_word_t excPc,
  input wire logic excCacheErr,
  input wire bbsc_pkg::bbsc_word_t excCacheInfo,
  input wire logic excReturn,
  output bbsc_pkg::bbsc_word_t excVector,
  output logic kernelMode,
  output logic floatEnable,
  output logic timerIrq,
  output logic irqRequest
);
  if (ADDR_W < 7) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end
  // ------
  // registers
  // ------
  bbsc_pkg::bbsc_word_t instr_space_base_ff, iLimit_ff, data_space_base_ff, dLimit_ff;
  bbsc_pkg::bbsc_word_t faultVaddr_ff, count_ff, match_ff;
  bbsc_pkg::bbsc_word_t state_ff, reasonSoft_ff, epc_ff, sysAttr_ff;
  bbsc_pkg::bbsc_word_t cPolicy_ff, fWatch_ff, data_breakpoint_addr_ff, cCheck_ff;
  bbsc_pkg::bbsc_word_t cErr_ff, cTag_ff, cfEpc_ff, wData_ff;
  logic [4:0] excCode_ff;
  logic timerPend_ff, tickPhase_ff, awHeld_ff, wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [3:0] wStrb_ff;
  function automatic bbsc_pkg::bbsc_word_t mergeBytes(
    input bbsc_pkg::bbsc_word_t old,
    input bbsc_pkg::bbsc_word_t data,
    input logic [3:0] strb);
    bbsc_pkg::bbsc_word_t res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction : mergeBytes
  function automatic logic inMap(input logic [ADDR_W-1:0] addr);
    return (addr >> 7) == '0;
  endfunction : inMap
  // ------
  // mode decode
  // ------
  logic userMode, regAccessOk;
  assign kernelMode = !state_ff[`BBSC_ST_USER] || state_ff[`BBSC_ST_EXL]
                      || state_ff[`BBSC_ST_ERL]; // [R3]
  assign userMode = !kernelMode;
  // user mode reaches the registers only when kernel granted it
  assign regAccessOk = kernelMode || state_ff[`BBSC_ST_CU0]; // [R4] [R5]
  assign floatEnable = state_ff[`BBSC_ST_CU1]; // [R4]
  assign timerIrq = timerPend_ff;
  assign irqRequest = timerPend_ff && state_ff[`BBSC_ST_IM_TIMER]
                      && state_ff[`BBSC_ST_IE] && !state_ff[`BBSC_ST_EXL]
                      && !state_ff[`BBSC_ST_ERL];
  // ------
  // AXI4-Lite write channel
  // ------
  logic wrFire, wrOk, regWr;
  logic [4:0] wrIdx;
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign wrIdx = awAddr_ff[6:2];
  assign wrOk = inMap(awAddr_ff) && regAccessOk;
  assign regWr = wrFire && wrOk;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= `BBSC_WORD_RST;
      wStrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bbsc_pkg::BBSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? bbsc_pkg::BBSC_RESP_OKAY
                            : bbsc_pkg::BBSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic hit(input logic [4:0] idx);
    return regWr && (wrIdx == idx);
  endfunction : hit
  function automatic bbsc_pkg::bbsc_word_t upd(
    input bbsc_pkg::bbsc_word_t old);
    return mergeBytes(old, wData_ff, wStrb_ff);
  endfunction : upd
  // ------
  // plain software registers
  // ------
  // unlisted numbers have no storage, so writes fall away [R20] [R22]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      instr_space_base_ff <= `BBSC_WORD_RST;
      iLimit_ff <= `BBSC_WORD_RST;
      data_space_base_ff <= `BBSC_WORD_RST;
      dLimit_ff <= `BBSC_WORD_RST;
      sysAttr_ff <= `BBSC_WORD_RST;
      cPolicy_ff <= `BBSC_CPOL_RST;
      fWatch_ff <= `BBSC_WORD_RST;
      data_breakpoint_addr_ff <= `BBSC_WORD_RST;
      cCheck_ff <= `BBSC_WORD_RST;
      cTag_ff <= `BBSC_WORD_RST;
    end else begin
      if (hit(`BBSC_IDX_INSTR_SPACE_BASE)) instr_space_base_ff <= upd(instr_space_base_ff);
      if (hit(`BBSC_IDX_ILIMIT)) iLimit_ff <= upd(iLimit_ff);
      if (hit(`BBSC_IDX_DATA_SPACE_BASE)) data_space_base_ff <= upd(data_space_base_ff);
      if (hit(`BBSC_IDX_DLIMIT)) dLimit_ff <= upd(dLimit_ff);
      if (hit(`BBSC_IDX_SYSATTR)) sysAttr_ff <= upd(sysAttr_ff);
      if (hit(`BBSC_IDX_CPOLICY)) cPolicy_ff <= upd(cPolicy_ff); // [R19]
      if (hit(`BBSC_IDX_FWATCH)) fWatch_ff <= upd(fWatch_ff);
      if (hit(`BBSC_IDX_DATA_BREAKPOINT_ADDR)) data_breakpoint_addr_ff <= upd(data_breakpoint_addr_ff);
      if (hit(`BBSC_IDX_CCHECK)) cCheck_ff <= upd(cCheck_ff);
      if (hit(`BBSC_IDX_CTAG)) cTag_ff <= upd(cTag_ff);
    end
  end
  // ------
  // cycle counter and timer match
  // ------
  logic countTick;
  bbsc_pkg::bbsc_word_t nxt_count;
  assign countTick = tickPhase_ff; // [R1]
  assign nxt_count = count_ff + 32'h0000_0001;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tickPhase_ff <= 1'b0;
      count_ff <= `BBSC_WORD_RST;
    end else begin
      tickPhase_ff <= !tickPhase_ff; // [R1]
      if (hit(`BBSC_IDX_COUNT)) begin
        count_ff <= upd(count_ff);
      end else if (countTick) begin
        count_ff <= nxt_count; // [R1]
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      match_ff <= `BBSC_WORD_RST;
      timerPend_ff <= 1'b0;
    end else begin
      if (hit(`BBSC_IDX_MATCH)) begin
        match_ff <= upd(match_ff);
      end
      // a fresh match beats the clear done by rewriting the match value
      if (countTick && !hit(`BBSC_IDX_COUNT) && nxt_count == match_ff) begin
        timerPend_ff <= 1'b1; // [R2]
      end else if (hit(`BBSC_IDX_MATCH)) begin
        timerPend_ff <= 1'b0;
      end
    end
  end
  // ------
  // translation ports
  // ------
  bbsc_pkg::bbsc_word_t fetchVaddrOut, dataVaddrOut;
  bbsc_addr_xlate u_fetch_xlate (
    .clk(clk), .reset_n(reset_n), .reqValid(fetchValid), .vaddr(fetchVaddr),
    .userMode(userMode), .spaceBase(instr_space_base_ff), .spaceLimit(iLimit_ff),
    .regionPolicy(cPolicy_ff), .watchAddr(fWatch_ff), .outValid(fetchDone),
    .outVaddr(fetchVaddrOut), .outPaddr(fetchPaddr), .outCached(fetchCached),
    .outPolicy(), .outFault(fetchFault), .outWatchHit(fetchWatchHit)
  );
  bbsc_addr_xlate u_data_xlate (
    .clk(clk), .reset_n(reset_n), .reqValid(dataValid), .vaddr(dataVaddr),
    .userMode(userMode), .spaceBase(data_space_base_ff), .spaceLimit(dLimit_ff),
    .regionPolicy(cPolicy_ff), .watchAddr(data_breakpoint_addr_ff), .outValid(dataDone),
    .outVaddr(dataVaddrOut), .outPaddr(dataPaddr), .outCached(dataCached),
    .outPolicy(dataPolicy), .outFault(dataFault), .outWatchHit(dataWatchHit)
  );
  // data fault wins when both sides fault in one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      faultVaddr_ff <= `BBSC_WORD_RST;
    end else if (dataFault) begin
      faultVaddr_ff <= dataVaddrOut; // [R17]
    end else if (fetchFault) begin
      faultVaddr_ff <= fetchVaddrOut; // [R17]
    end
  end
  // ------
  // mode, exception state and return addresses
  // ------
  logic excIsIntr;
  assign excIsIntr = (excCode == bbsc_pkg::BBSC_EXC_INTR);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= `BBSC_STATE_RST; // [R3]
    end else if (excValid) begin
      if (excCacheErr) begin
        state_ff[`BBSC_ST_ERL] <= 1'b1; // [R3]
      end else begin
        state_ff[`BBSC_ST_EXL] <= 1'b1; // [R3]
      end
    end else if (excReturn) begin
      if (state_ff[`BBSC_ST_ERL]) begin
        state_ff[`BBSC_ST_ERL] <= 1'b0;
      end else begin
        state_ff[`BBSC_ST_EXL] <= 1'b0;
      end
    end else if (hit(`BBSC_IDX_STATE)) begin
      state_ff <= upd(state_ff); // [R4] [R16]
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      epc_ff <= `BBSC_WORD_RST;
      cfEpc_ff <= `BBSC_WORD_RST;
      cErr_ff <= `BBSC_WORD_RST;
      excCode_ff <= 5'h00;
    end else if (excValid) begin
      if (excCacheErr) begin
        cfEpc_ff <= excPc; // [R18]
        cErr_ff <= excCacheInfo;
      end else begin
        epc_ff <= excPc;
        excCode_ff <= excCode;
      end
    end else begin
      if (hit(`BBSC_IDX_EPC)) epc_ff <= upd(epc_ff);
      if (hit(`BBSC_IDX_CFEPC)) cfEpc_ff <= upd(cfEpc_ff); // [R18]
    end
  end
  // only the two software interrupt bits of the reason word are writable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reasonSoft_ff <= `BBSC_WORD_RST;
    end else if (hit(`BBSC_IDX_REASON)) begin
      reasonSoft_ff <= upd(reasonSoft_ff) & `BBSC_RS_SOFT_MASK;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      excVector <= `BBSC_VEC_GENERAL;
    end else if (excValid) begin
      excVector <= (excIsIntr && state_ff[`BBSC_ST_IVEC])
                   ? `BBSC_VEC_INTR : `BBSC_VEC_GENERAL; // [R16]
    end
  end
  // ------
  // AXI4-Lite read channel
  // ------
  bbsc_pkg::bbsc_word_t rdMux, reasonWord;
  always_comb begin
    reasonWord = reasonSoft_ff;
    reasonWord[`BBSC_RS_CODE_LO +: 5] = excCode_ff;
    reasonWord[`BBSC_RS_TIMER] = timerPend_ff;
  end
  always_comb begin
    case (s_axi_araddr[6:2])
      `BBSC_IDX_INSTR_SPACE_BASE: rdMux = instr_space_base_ff;
      `BBSC_IDX_ILIMIT: rdMux = iLimit_ff;
      `BBSC_IDX_DATA_SPACE_BASE: rdMux = data_space_base_ff;
      `BBSC_IDX_DLIMIT: rdMux = dLimit_ff;
      `BBSC_IDX_FVADDR: rdMux = faultVaddr_ff;
      `BBSC_IDX_COUNT: rdMux = count_ff;
      `BBSC_IDX_MATCH: rdMux = match_ff;
      `BBSC_IDX_STATE: rdMux = state_ff;
      `BBSC_IDX_REASON: rdMux = reasonWord;
      `BBSC_IDX_EPC: rdMux = epc_ff;
      `BBSC_IDX_IDENT: rdMux = IDENT_VALUE;
      `BBSC_IDX_SYSATTR: rdMux = sysAttr_ff;
      `BBSC_IDX_CPOLICY: rdMux = cPolicy_ff;
      `BBSC_IDX_FWATCH: rdMux = fWatch_ff;
      `BBSC_IDX_DATA_BREAKPOINT_ADDR: rdMux = data_breakpoint_addr_ff;
      `BBSC_IDX_CCHECK: rdMux = cCheck_ff;
      `BBSC_IDX_CERR: rdMux = cErr_ff;
      `BBSC_IDX_CTAG: rdMux = cTag_ff;
      `BBSC_IDX_CFEPC: rdMux = cfEpc_ff;
      default: rdMux = `BBSC_WORD_RST; // [R20] [R22]
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `BBSC_WORD_RST;
      s_axi_rresp <= bbsc_pkg::BBSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (inMap(s_axi_araddr) && regAccessOk) begin // [R5]
        s_axi_rdata <= rdMux;
        s_axi_rresp <= bbsc_pkg::BBSC_RESP_OKAY;
      end else begin
        s_axi_rdata <= `BBSC_WORD_RST;
        s_axi_rresp <= bbsc_pkg::BBSC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : bbsc_system_control

// file: dv/bbsc_sc_sva.sv
// Purpose: port checks of the system control coprocessor
// Assumes: sees the top module's ports only
// Notes: bound to the design at the foot of this file
`include "bbsc_map.svh"
module bbsc_sc_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fetchValid,
  input wire bbsc_pkg::bbsc_word_t fetchVaddr,
  input wire logic fetchDone,
  input wire bbsc_pkg::bbsc_word_t fetchPaddr,
  input wire logic fetchCached,
  input wire logic fetchFault,
  input wire logic dataValid,
  input wire bbsc_pkg::bbsc_word_t dataVaddr,
  input wire logic dataDone,
  input wire logic dataFault,
  input wire logic excValid,
  input wire logic [4:0] excCode,
  input wire bbsc_pkg::bbsc_word_t excVector,
  input wire logic kernelMode,
  input wire logic timerIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_FDONE: assert property (fetchValid |=> fetchDone)
    else $error("fetch result missing");
  AST_DDONE: assert property (dataValid |=> dataDone)
    else $error("data result missing");
  AST_CWIN: assert property (fetchValid && kernelMode &&
    fetchVaddr[31:29] == 3'b100 |=> fetchCached &&
    fetchPaddr == {3'b000, $past(fetchVaddr[28:0])})
    else $error("cached window translation wrong");
  AST_UWIN: assert property (fetchValid && kernelMode &&
    fetchVaddr[31:29] == 3'b101 |=> !fetchCached &&
    fetchPaddr == {3'b000, $past(fetchVaddr[28:0])})
    else $error("uncached window translation wrong");
  AST_UFLT: assert property (fetchValid && !kernelMode &&
    fetchVaddr[31] |=> fetchFault) else $error("user fetch not refused");
  AST_DFLT: assert property (dataValid && !kernelMode &&
    dataVaddr[31] |=> dataFault) else $error("user data not refused");
  AST_KNOF: assert property (fetchValid && kernelMode |=> !fetchFault)
    else $error("kernel fetch faulted");
  AST_EXCK: assert property (excValid |=> kernelMode)
    else $error("exception left user mode");
  AST_GVEC: assert property (excValid && excCode != 5'h00 |=>
    excVector == `BBSC_VEC_GENERAL) else $error("general vector wrong");
  cover property (fetchDone && fetchFault);
  cover property (dataDone && !dataFault);
  cover property ($rose(timerIrq));
endmodule : bbsc_sc_sva

bind bbsc_system_control bbsc_sc_sva bbsc_sc_sva_i (.clk, .reset_n,
  .fetchValid, .fetchVaddr, .fetchDone, .fetchPaddr, .fetchCached,
  .fetchFault, .dataValid, .dataVaddr, .dataDone, .dataFault, .excValid,
  .excCode, .excVector, .kernelMode, .timerIrq);

// file: dv/bbsc_pipe_model.sv
// Purpose: pipeline side: translation requests and exception reports
// Assumes: requests are one-cycle pulses on clk
// Notes: released address lines show the inverse of the last value
module bbsc_pipe_model (
  input wire logic clk,
  output logic fetchValid = 1'b0,
  output bbsc_pkg::bbsc_word_t fetchVaddr = '0,
  output logic dataValid = 1'b0,
  output bbsc_pkg::bbsc_word_t dataVaddr = '0,
  output logic excValid = 1'b0,
  output logic [4:0] excCode = 5'h00,
  output bbsc_pkg::bbsc_word_t excPc = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic xl(input bit d, input bbsc_pkg::bbsc_word_t v);
    @(posedge clk);
    if (d) begin dataValid <= 1'b1; dataVaddr <= v; end
    else begin fetchValid <= 1'b1; fetchVaddr <= v; end
    @(posedge clk);
    fetchValid <= 1'b0;
    dataValid <= 1'b0;
    if (d) dataVaddr <= ~v; else fetchVaddr <= ~v;
  endtask : xl
  task automatic ex(input logic [4:0] c, input bbsc_pkg::bbsc_word_t pc);
    @(posedge clk);
    excValid <= 1'b1; excCode <= c; excPc <= pc;
    @(posedge clk);
    excValid <= 1'b0; excCode <= ~c; excPc <= ~pc;
  endtask : ex
endmodule : bbsc_pipe_model

// file: dv/tb.sv
// Purpose: self-checking bench of the system control coprocessor
// Assumes: AXI4-Lite master and pipeline model drive the block
// Notes: expected results queued, a monitor compares them
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fetchValid, fetchDone, fetchCached, fetchFault;
  logic dataValid, dataDone, dataFault, dataWatchHit, excValid;
  logic kernelMode, floatEnable, timerIrq, cerr = 0;
  logic [4:0] excCode;
  bbsc_pkg::bbsc_word_t s_axi_wdata = '0, s_axi_rdata, fetchVaddr;
  bbsc_pkg::bbsc_word_t fetchPaddr, dataVaddr, dataPaddr, excVector, excPc;
  bbsc_pkg::bbsc_word_t ib, il, db, dl, v;
  int err_count = 0, n_compared = 0, cyc = 0;
  logic [32:0] rq[$], fq[$], dq[$];
  always #25 clk = ~clk;
  bbsc_system_control bbsc_system_control_i (.clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready, .fetchValid,
    .fetchVaddr, .fetchDone, .fetchPaddr, .fetchCached, .fetchFault,
    .fetchWatchHit(), .dataValid, .dataVaddr, .dataDone, .dataPaddr,
    .dataCached(), .dataPolicy(), .dataFault, .dataWatchHit, .excValid,
    .excCode, .excPc, .excCacheErr(cerr), .excCacheInfo(32'h0000_0000),
    .excReturn(1'b0), .excVector, .kernelMode, .floatEnable, .timerIrq,
    .irqRequest());
  bbsc_pipe_model bbsc_pipe_model_i (.clk, .fetchValid, .fetchVaddr,
    .dataValid, .dataVaddr, .excValid, .excCode, .excPc);
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input bbsc_pkg::bbsc_word_t d);
    bit pa, pw;
    pa = 1; pw = 1;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      s_axi_awvalid <= pa; s_axi_wvalid <= pw;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input bbsc_pkg::bbsc_word_t e);
    rq.push_back({1'b0, e});
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  // fault result carries a zero address
  function automatic logic [32:0] xp(bit k, bbsc_pkg::bbsc_word_t a,
    bbsc_pkg::bbsc_word_t b, bbsc_pkg::bbsc_word_t l);
    if (!k) return (a[31] || a > l) ? {1'b1, 32'h0000_0000} : {1'b0, a + b};
    return {1'b0, a[31:30] == 2'b10 ? {3'b000, a[28:0]} : a};
  endfunction : xp
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata, rq.pop_front());
    if (fetchDone) check({fetchFault, fetchPaddr}, fq.pop_front());
    if (dataDone) check({dataFault, dataPaddr}, dq.pop_front());
    if (++cyc > 4000) begin err_count++; finish_test; end
  end
  initial begin
    void'($urandom(14));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h30, 32'h0000_0004);
    rd(8'h44, 32'h3333_3333);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    ib = $urandom; il = $urandom_range(32'h7fff_0000, 32'h0001_0000);
    db = $urandom; dl = $urandom_range(32'h7fff_0000, 32'h0001_0000);
    wr(8'h00, ib); wr(8'h04, il); wr(8'h08, db); wr(8'h0c, dl);
    for (int i = 0; i < 8; i++) begin
      v = {3'(4 + i % 4), 29'($urandom)};
      fq.push_back(xp(1, v, ib, il));
      bbsc_pipe_model_i.xl(0, v);
    end
    wr(8'h30, 32'h1000_0010);
    check(kernelMode, 1'b0);
    for (int i = 0; i < 18; i++) begin
      v = $urandom_range((i[0] ? dl : il) + 32'h0010_0000, 0);
      if (i % 4 == 3) v[31] = 1'b1;
      if (i >= 16) v = dl + 4 * (i - 16);
      if (i[0] || i >= 16) dq.push_back(xp(0, v, db, dl));
      else fq.push_back(xp(0, v, ib, il));
      bbsc_pipe_model_i.xl(i[0] || i >= 16, v);
    end
    rd(8'h20, dl + 4);
    v = dl & 32'hffff_fffc;
    wr(8'h4c, v | 32'h0000_0001);
    dq.push_back(xp(0, v, db, dl));
    bbsc_pipe_model_i.xl(1, v);
    @(negedge clk) check(dataWatchHit, 1'b1);
    bbsc_pipe_model_i.ex(5'h04, 32'h0000_1234);
    @(negedge clk) check(kernelMode, 1'b1);
    rd(8'h38, 32'h0000_1234);
    wr(8'h2c, 32'h0000_0008); wr(8'h24, 32'h0000_0000);
    repeat (13) @(posedge clk);
    @(negedge clk) check(timerIrq, 1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk) check(timerIrq, 1'b1);
    wr(8'h2c, 32'hffff_0000);
    @(negedge clk) check(timerIrq, 1'b0);
    wr(8'h30, 32'h2100_0002);
    @(negedge clk) check(floatEnable, 1'b1);
    bbsc_pipe_model_i.ex(5'h00, 32'h0000_2000);
    @(negedge clk) check(excVector, 32'h8000_0200);
    @(posedge clk) cerr <= 1'b1;
    bbsc_pipe_model_i.ex(5'h00, 32'h0000_3000);
    cerr <= 1'b0;
    rd(8'h78, 32'h0000_3000);
    rd(8'h38, 32'h0000_2000);
    finish_test;
  end
endmodule : tb
